// [rtc_regs.sv]
// Configuration register bank for loop offset, supply lockout, good window and tracking.
`include "rtc_defs.svh"

module rtc_regs (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire rtc_pkg::rtc_byte_t reg_wdata,
  output rtc_pkg::rtc_byte_t     reg_rdata,
  output logic                   reg_hit,
  input  wire logic              tracking_input_valid,
  input  wire logic              switch_request,
  output logic                   switch_enable,
  output logic                   offset_scheme_select,
  output logic [1:0]             offset_trim_code,
  output logic [3:0]             offset_added_mv,
  output logic [2:0]             lockout_threshold_code,
  output logic [13:0]            lockout_threshold_mv,
  output logic                   good_window_select,
  output logic [5:0]             good_window_high_pct,
  output logic [5:0]             good_window_low_pct,
  output logic                   user_flag_output,
  output logic                   track_gate_bypass,
  output logic [3:0]             track_target_code,
  output logic [10:0]            track_target_mv
);
  logic       ofs_sel;
  logic [1:0] ofs_trim;
  logic [2:0] uv_code;
  logic       gw_sel;
  logic       spare;
  logic       byp;
  logic [3:0] tgt;
  logic       next_ofs_sel;
  logic [1:0] next_ofs_trim;
  logic [2:0] next_uv_code;
  logic       next_gw_sel;
  logic       next_spare;
  logic       next_byp;
  logic [3:0] next_tgt;
  logic       trk_s1;
  logic       trk_s2;
  logic       trk_s3;
  logic       trk_ok;
  logic       next_trk_ok;

  // Host writes update only writable fields; other bits are dropped.
  always_comb begin
    next_ofs_sel  = ofs_sel;
    next_ofs_trim = ofs_trim;
    next_uv_code  = uv_code;
    next_gw_sel   = gw_sel;
    next_spare    = spare;
    next_byp      = byp;
    next_tgt      = tgt;
    if (reg_wr) begin
      case (reg_addr)
        `RTC_ADDR_OFFSET: begin
          next_ofs_sel  = reg_wdata[`RTC_OFS_SEL_BIT];
          next_ofs_trim = reg_wdata[`RTC_OFS_TRIM_HI:`RTC_OFS_TRIM_LO];
        end
        `RTC_ADDR_LOCKOUT: begin
          next_uv_code = reg_wdata[`RTC_UV_HI:`RTC_UV_LO];
        end
        `RTC_ADDR_TRACK: begin
          next_gw_sel = reg_wdata[`RTC_GW_BIT];
          next_spare  = reg_wdata[`RTC_SPARE_BIT];
          next_byp    = reg_wdata[`RTC_BYP_BIT];
          next_tgt    = reg_wdata[`RTC_TGT_HI:`RTC_TGT_LO];
        end
        default: begin
          next_ofs_sel = ofs_sel;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ofs_sel  <= `RTC_RST_OFS_SEL;
      ofs_trim <= `RTC_RST_OFS_TRIM;
      uv_code  <= `RTC_RST_UV;
      gw_sel   <= `RTC_RST_GW;
      spare    <= `RTC_RST_SPARE;
      byp      <= `RTC_RST_BYP;
      tgt      <= `RTC_RST_TGT;
    end else if (clk_en) begin
      ofs_sel  <= next_ofs_sel;
      ofs_trim <= next_ofs_trim;
      uv_code  <= next_uv_code;
      gw_sel   <= next_gw_sel;
      spare    <= next_spare;
      byp      <= next_byp;
      tgt      <= next_tgt;
    end
  end

  // The tracking comparator comes from the analog side, so it is synchronised.
  always_comb begin
    next_trk_ok = trk_ok;
    if (trk_s2 == trk_s3) begin
      next_trk_ok = trk_s3;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trk_s1 <= 1'h0;
      trk_s2 <= 1'h0;
      trk_s3 <= 1'h0;
      trk_ok <= 1'h0;
    end else if (clk_en) begin
      trk_s1 <= tracking_input_valid;
      trk_s2 <= trk_s1;
      trk_s3 <= trk_s2;
      trk_ok <= next_trk_ok;
    end
  end

  // Read-back assembles fields with zeros in unused positions.
  always_comb begin
    reg_hit   = 1'h0;
    reg_rdata = 8'h00;
    case (reg_addr)
      `RTC_ADDR_OFFSET: begin
        reg_hit   = 1'h1;
        reg_rdata = {ofs_sel, ofs_trim, 5'h00};
      end
      `RTC_ADDR_LOCKOUT: begin
        reg_hit   = 1'h1;
        reg_rdata = {5'h00, uv_code};
      end
      `RTC_ADDR_TRACK: begin
        reg_hit   = 1'h1;
        reg_rdata = {gw_sel, spare, 1'h0, byp, tgt};
      end
      default: begin
        reg_rdata = 8'h00;
      end
    endcase
  end

  // Decoded settings for the analog circuits.
  always_comb begin
    offset_added_mv = 4'h0;
    if (!ofs_sel) begin
      offset_added_mv = 4'({2'h0, ofs_trim} * `RTC_TRIM_STEP_MV);
    end
    case (uv_code)
      3'h4:    lockout_threshold_mv = 14'hAF0;
      3'h5:    lockout_threshold_mv = 14'h109A;
      3'h6:    lockout_threshold_mv = 14'h1770;
      3'h7:    lockout_threshold_mv = 14'h1FA4;
      default: lockout_threshold_mv = `RTC_UV_DEFAULT_MV;
    endcase
    if (gw_sel) begin
      good_window_high_pct = 6'h14;
      good_window_low_pct  = 6'h20;
    end else begin
      good_window_high_pct = 6'h10;
      good_window_low_pct  = 6'h10;
    end
    track_target_mv = 11'(`RTC_TGT_BASE_MV + {7'h00, tgt} * `RTC_TGT_STEP_MV);
  end

  assign offset_scheme_select   = ofs_sel;
  assign offset_trim_code       = ofs_trim;
  assign lockout_threshold_code = uv_code;
  assign good_window_select     = gw_sel;
  assign user_flag_output       = spare;
  assign track_gate_bypass      = byp;
  assign track_target_code      = tgt;
  assign switch_enable          = switch_request && (byp || trk_ok);

  unused_bits_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_addr == `RTC_ADDR_TRACK) |-> !reg_rdata[5])
    else $error("Unused bit read as one.");
  ro_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && clk_en && reg_addr == `RTC_ADDR_OFFSET) |=> (reg_rdata[4:0] == 5'h00
      || reg_addr != `RTC_ADDR_OFFSET))
    else $error("Read-only bits changed.");
  write_back_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && clk_en && reg_addr == `RTC_ADDR_TRACK) |=> (tgt == $past(reg_wdata[3:0])))
    else $error("Target write lost.");
  trim_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    ofs_sel |-> (offset_added_mv == 4'h0))
    else $error("Trim applied in automatic mode.");
  trim_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!ofs_sel && ofs_trim == 2'h3) |-> (offset_added_mv == 4'h6))
    else $error("Trim step wrong.");
  lockout_hi_a: assert property (@(posedge clk) disable iff (!arst_n)
    !uv_code[2] |-> (lockout_threshold_mv == 14'h27D8))
    else $error("Lockout default threshold wrong.");
  window_a: assert property (@(posedge clk) disable iff (!arst_n)
    !gw_sel |-> (good_window_low_pct == 6'h10))
    else $error("Good window wrong.");
  gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (switch_enable && !byp) |-> trk_ok)
    else $error("Switching without tracking valid.");
  target_top_a: assert property (@(posedge clk) disable iff (!arst_n)
    (tgt == 4'hF) |-> (track_target_mv == 11'h4E2))
    else $error("Target decode wrong.");
  spare_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && clk_en && reg_addr == `RTC_ADDR_TRACK) |=> (user_flag_output == $past(reg_wdata[6])))
    else $error("Spare output not following.");

  // Steps of the tracking synchroniser while state may advance.
  sequence sync_high_s;
    clk_en && trk_s2 && trk_s3;
  endsequence
  sequence sync_low_s;
    clk_en && !trk_s2 && !trk_s3;
  endsequence
  sequence sync_split_s;
    clk_en && (trk_s2 != trk_s3);
  endsequence

  sync_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
    sync_high_s |=> trk_ok)
    else $error("Tracking valid not accepted.");
  sync_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
    sync_low_s |=> !trk_ok)
    else $error("Tracking valid not dropped.");
  sync_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    sync_split_s |=> $stable(trk_ok))
    else $error("Tracking valid changed on disagreement.");
  freeze_regs_a: assert property (@(posedge clk) disable iff (!arst_n)
    !clk_en |=> ($stable(uv_code) && $stable(tgt) && $stable(ofs_trim)))
    else $error("Registers changed while frozen.");
  read_ofs_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_addr == `RTC_ADDR_OFFSET) |-> (reg_rdata[4:0] == 5'h00))
    else $error("Offset unused bits not zero.");
  read_uv_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_addr == `RTC_ADDR_LOCKOUT) |-> (reg_rdata[7:3] == 5'h00))
    else $error("Lockout unused bits not zero.");
  hit_map_a: assert property (@(posedge clk) disable iff (!arst_n)
    reg_hit == (reg_addr == 8'hD4 || reg_addr == 8'hD6 || reg_addr == 8'hD7))
    else $error("Address decode wrong.");
  unmapped_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_hit |-> (reg_rdata == 8'h00))
    else $error("Unmapped read not zero.");
  wr_ofs_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && clk_en && reg_addr == `RTC_ADDR_OFFSET) |=>
      (ofs_sel == $past(reg_wdata[7]) && ofs_trim == $past(reg_wdata[6:5])))
    else $error("Offset write lost.");
  wr_uv_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && clk_en && reg_addr == `RTC_ADDR_LOCKOUT) |=> (uv_code == $past(reg_wdata[2:0])))
    else $error("Lockout write lost.");
  wr_track_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && clk_en && reg_addr == `RTC_ADDR_TRACK) |=>
      (gw_sel == $past(reg_wdata[7]) && byp == $past(reg_wdata[4])))
    else $error("Tracking write lost.");
  stray_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && !reg_hit) |=> ($stable(ofs_sel) && $stable(uv_code) && $stable(tgt)))
    else $error("Unmapped write changed state.");
  hold_regs_a: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_wr |=> ($stable(ofs_sel) && $stable(ofs_trim) && $stable(uv_code)
      && $stable(gw_sel) && $stable(spare) && $stable(byp) && $stable(tgt)))
    else $error("Registers changed without write.");
  lockout_low_a: assert property (@(posedge clk) disable iff (!arst_n)
    (uv_code == 3'h4) |-> (lockout_threshold_mv == 14'hAF0))
    else $error("Lockout code four wrong.");
  lockout_mid_a: assert property (@(posedge clk) disable iff (!arst_n)
    (uv_code == 3'h5) |-> (lockout_threshold_mv == 14'h109A))
    else $error("Lockout code five wrong.");
  lockout_six_a: assert property (@(posedge clk) disable iff (!arst_n)
    (uv_code == 3'h6) |-> (lockout_threshold_mv == 14'h1770))
    else $error("Lockout code six wrong.");
  lockout_top_a: assert property (@(posedge clk) disable iff (!arst_n)
    (uv_code == 3'h7) |-> (lockout_threshold_mv == 14'h1FA4))
    else $error("Lockout code seven wrong.");
  window_wide_a: assert property (@(posedge clk) disable iff (!arst_n)
    gw_sel |-> (good_window_high_pct == 6'h14 && good_window_low_pct == 6'h20))
    else $error("Wide good window wrong.");
  window_narrow_a: assert property (@(posedge clk) disable iff (!arst_n)
    !gw_sel |-> (good_window_high_pct == 6'h10))
    else $error("Narrow good window wrong.");
  trim_one_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!ofs_sel && ofs_trim == 2'h1) |-> (offset_added_mv == 4'h2))
    else $error("Trim code one wrong.");
  trim_two_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!ofs_sel && ofs_trim == 2'h2) |-> (offset_added_mv == 4'h4))
    else $error("Trim code two wrong.");
  target_base_a: assert property (@(posedge clk) disable iff (!arst_n)
    (tgt == 4'h0) |-> (track_target_mv == 11'h1F4))
    else $error("Target base wrong.");
  bypass_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (switch_request && byp) |-> switch_enable)
    else $error("Bypass did not enable switching.");
  no_request_a: assert property (@(posedge clk) disable iff (!arst_n)
    !switch_request |-> !switch_enable)
    else $error("Switching without request.");
endmodule // rtc_regs

// [rtc_defs.svh]
// Register offsets, field positions, reset values and decode constants of the trim registers.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define RTC_ADDR_OFFSET         8'hD4
`define RTC_ADDR_LOCKOUT        8'hD6
`define RTC_ADDR_TRACK          8'hD7
`define RTC_OFS_SEL_BIT         7
`define RTC_OFS_TRIM_HI         6
`define RTC_OFS_TRIM_LO         5
`define RTC_UV_HI               2
`define RTC_UV_LO               0
`define RTC_GW_BIT              7
`define RTC_SPARE_BIT           6
`define RTC_BYP_BIT             4
`define RTC_TGT_HI              3
`define RTC_TGT_LO              0
`define RTC_RST_OFS_SEL         1'h1
`define RTC_RST_OFS_TRIM        2'h0
`define RTC_RST_UV              3'h5
`define RTC_RST_GW              1'h1
`define RTC_RST_SPARE           1'h0
`define RTC_RST_BYP             1'h0
`define RTC_RST_TGT             4'hF
`define RTC_TRIM_STEP_MV        8'h02
`define RTC_TGT_BASE_MV         11'h1F4
`define RTC_TGT_STEP_MV         11'h032
`define RTC_UV_DEFAULT_MV       14'h27D8
`endif

// [rtc_pkg.sv]
// Types shared by the trim register bank.
package rtc_pkg;
  typedef logic [7:0] rtc_byte_t;
endpackage

// [rtc_host.sv]
// Host model that issues single-byte accesses to the trim registers.
module rtc_host (
  input  wire logic          clk,
  output logic [7:0]         reg_addr,
  output logic               reg_wr,
  output rtc_pkg::rtc_byte_t reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // Holds one write for a single edge, then scrambles the data lines.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic sel(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
  endtask
endmodule // rtc_host

// [rtc_regs_tb.sv]
// Self-checking bench for the trim register bank.
module rtc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, ok = 1'b0, req = 1'b0;
  logic [7:0]  addr, wdata, rdata;
  logic        wr, hit, sw, sel, gw, flag, byp;
  logic [1:0]  trim;
  logic [2:0]  uv;
  logic [3:0]  ofs, tgt;
  logic [13:0] uv_mv;
  logic [5:0]  hi, lo;
  logic [10:0] tgt_mv;
  int          failures = 0, checked = 0, n;
  logic [13:0] uvt [8] = '{14'h27D8, 14'h27D8, 14'h27D8, 14'h27D8,
                           14'h0AF0, 14'h109A, 14'h1770, 14'h1FA4};
  always #5 clk = ~clk;
  rtc_host i_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata));
  rtc_regs i_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(addr),
    .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit),
    .tracking_input_valid(ok), .switch_request(req), .switch_enable(sw),
    .offset_scheme_select(sel), .offset_trim_code(trim), .offset_added_mv(ofs),
    .lockout_threshold_code(uv), .lockout_threshold_mv(uv_mv),
    .good_window_select(gw), .good_window_high_pct(hi), .good_window_low_pct(lo),
    .user_flag_output(flag), .track_gate_bypass(byp), .track_target_code(tgt),
    .track_target_mv(tgt_mv));
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic results();
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host.sel(a);
    @(negedge clk);
    chk("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  task automatic t_reset();
    rd(8'hD4, 8'h80);
    rd(8'hD6, 8'h05);
    rd(8'hD7, 8'h8F);
    chk("window", {4'h0, hi, lo}, 16'h0520);
    chk("uv_mv", {2'h0, uv_mv}, 16'h109A);
    chk("flag_sw", {14'h0000, flag, sw}, 16'h0000);
  endtask
  task automatic t_fields();
    i_host.wr(8'hD4, 8'hFF);
    rd(8'hD4, 8'hE0);
    chk("ofs", {12'h000, ofs}, 16'h0000);
    chk("sel_trim", {13'h0000, sel, trim}, 16'h0007);
    chk("hit", {15'h0000, hit}, 16'h0001);
    i_host.wr(8'hD6, 8'hFF);
    rd(8'hD6, 8'h07);
    chk("uv", {13'h0000, uv}, 16'h0007);
    i_host.wr(8'hD7, 8'hFF);
    rd(8'hD7, 8'hDF);
    chk("flag", {15'h0000, flag}, 16'h0001);
    chk("codes", {10'h000, gw, byp, tgt}, 16'h003F);
    i_host.wr(8'hD7, 8'h00);
    rd(8'hD7, 8'h00);
    chk("window", {4'h0, hi, lo}, 16'h0410);
  endtask
  task automatic t_codes();
    for (int i = 0; i < 4; i++) begin
      i_host.wr(8'hD4, {1'b0, 2'(i), 5'h1F});
      rd(8'hD4, {1'b0, 2'(i), 5'h00});
      chk("ofs", {12'h000, ofs}, 16'(i * 2));
    end
    for (int i = 0; i < 8; i++) begin
      i_host.wr(8'hD6, 8'(i));
      @(negedge clk);
      chk("uv_mv", {2'h0, uv_mv}, {2'h0, uvt[i]});
    end
    for (int i = 0; i < 16; i++) begin
      i_host.wr(8'hD7, 8'(i));
      @(negedge clk);
      chk("tgt_mv", {5'h00, tgt_mv}, {5'h00, 11'h1F4 + 11'h032 * 11'(i)});
    end
  endtask
  task automatic t_refuse();
    i_host.wr(8'hD5, 8'hFF);
    rd(8'hD5, 8'h00);
    chk("hit", {15'h0000, hit}, 16'h0000);
    @(posedge clk);
    clk_en <= 1'b0;
    i_host.wr(8'hD6, 8'h04);
    clk_en <= 1'b1;
    rd(8'hD6, 8'h07);
  endtask
  task automatic t_track();
    @(posedge clk);
    req <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("sw", {15'h0000, sw}, 16'h0000);
    @(posedge clk);
    ok <= 1'b1;
    n = 0;
    while (sw !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      failures++;
      results();
    end
    @(posedge clk);
    ok <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("sw", {15'h0000, sw}, 16'h0000);
    i_host.wr(8'hD7, 8'h10);
    @(negedge clk);
    chk("sw", {14'h0000, byp, sw}, 16'h0003);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_codes();
    t_refuse();
    t_track();
    results();
  end
endmodule // rtc_regs_tb
